// ===== core/fgc_params.svh
`ifndef FGC_PARAMS_SVH
`define FGC_PARAMS_SVH

// Core clock and link timing
`define FGC_CLK_HZ 25000000
`define FGC_LINK_BPS 625000
`define FGC_LINK_BIT_CYCLES (`FGC_CLK_HZ / `FGC_LINK_BPS)

// Switch positions with a documented meaning, and the switch sampling delay
`define FGC_LINK_RATE_POS_625K 4'h7
`define FGC_LINK_RATE_POS_FIRST_BAD 4'h8
`define FGC_FB_RATE_POS_10M 4'h4
`define FGC_SAMPLE_DELAY 2'h3

// Window layout
`define FGC_NUM_CHAN 4
`define FGC_WORDS_PER_CHAN 4
`define FGC_NUM_WORDS 16

// Host register byte offsets
`define FGC_REG_REQ_CTRL 8'h00
`define FGC_REG_END_STATUS 8'h04
`define FGC_REG_WR_BASE 8'h40
`define FGC_REG_RD_BASE 8'h80
`define FGC_REG_WIN_END 8'hc0

// Reset values
`define FGC_REQ_RESET 4'h0
`define FGC_WORD_RESET 16'h0000

// Bus answers
`define FGC_RESP_OKAY 2'h0
`define FGC_RESP_SLVERR 2'h2

`endif

// ===== core/fgc_pkg.sv
package fgc_pkg;
  typedef logic [15:0] fgc_word_type;
  typedef fgc_word_type [15:0] fgc_window_type;
  typedef fgc_word_type [3:0] fgc_chan_words_type;
  typedef logic [3:0] fgc_chan_mask_type;
endpackage

// ===== core/fgc_link_if.sv
`timescale 1ns/1ns
interface fgc_link_if;
  import fgc_pkg::*;
  fgc_chan_mask_type req;
  fgc_chan_mask_type done;
  fgc_window_type wr_words;
  fgc_window_type rd_words;

  modport gateway (
    input req,
    input wr_words,
    output done,
    output rd_words
  );

  modport master (
    output req,
    output wr_words,
    input done,
    input rd_words
  );
endinterface

// ===== core/fgc_gateway.sv
// Contract
// - Switches sampled once after power-up only
// - Protocol switch ON selects Modbus, OFF gateway
// - Rotary switch gives unit address 0 to 15
// - Integrator keeps unit addresses unique per link
// - Rate position 7 gives 625000 bps link
// - Gateway reads attached-unit count switch
// - Fieldbus rate position 4 means 10 Mbps
// - Station number from tens and units digits
// - Each channel owns four write, four read words
// - Channels 0,1 use words 0-3, 4-7
// - Channels 2,3 use words 8-B, C-F
// - Master sets four stations, extended cyclic two
// - Completion only after reply words are valid
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`include "fgc_params.svh"

module fgc_gateway #(
  parameter int LINK_BIT_CYCLES = `FGC_LINK_BIT_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Fieldbus side
  fgc_link_if.gateway link,
  // Configuration switches, asynchronous pins
  input wire logic protocol_select_switch_in,
  input wire logic [3:0] address_rotary_switch_in,
  input wire logic address_extension_switch_in,
  input wire logic [3:0] link_rate_selector_in,
  input wire logic [3:0] attached_unit_count_switch_in,
  input wire logic [3:0] fieldbus_rate_switch_in,
  input wire logic [3:0] station_units_switch_in,
  input wire logic [3:0] station_tens_switch_in,
  // Latched configuration
  output logic config_valid_out,
  output logic modbus_mode_out,
  output logic [4:0] unit_address_out,
  output logic link_rate_error_out,
  output logic link_bit_tick_out,
  output logic [3:0] unit_count_out,
  output logic fieldbus_10m_out,
  output logic [6:0] station_number_out,
  // Command toward the serial drivers
  output logic cmd_valid_out,
  output logic [1:0] cmd_chan_out,
  output fgc_pkg::fgc_chan_words_type cmd_words_out,
  input wire logic resp_valid_in,
  input wire fgc_pkg::fgc_chan_words_type resp_words_in
);
  import fgc_pkg::*;

  localparam int SW_W = 26;

  // Tick counter is six bits wide
  if (LINK_BIT_CYCLES < 2 || LINK_BIT_CYCLES > 64) begin : g_bad_cycles
    $error("LINK_BIT_CYCLES must be 2 to 64");
  end

  typedef enum logic [1:0] {
    fgc_scan_type_idle,
    fgc_scan_type_issue,
    fgc_scan_type_wait
  } fgc_scan_type;

  logic [SW_W-1:0] sw_meta_ff;
  logic [SW_W-1:0] sw_sync_ff;
  logic [1:0] sample_cnt_ff;
  logic sampled_ff;
  logic [3:0] link_rate_ff;
  logic [5:0] tick_cnt_ff;
  fgc_scan_type state_ff;
  logic [1:0] chan_ff;
  fgc_chan_mask_type done_ff;
  fgc_window_type rd_words_ff;
  logic [3:0] sw_units;
  logic [3:0] sw_tens;
  logic [3:0] sw_rate;

  // Raw pins only feed the first stage
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sw_meta_ff <= '0;
      sw_sync_ff <= '0;
    end else begin
      sw_meta_ff <= {protocol_select_switch_in, address_rotary_switch_in,
                     address_extension_switch_in, link_rate_selector_in,
                     attached_unit_count_switch_in, fieldbus_rate_switch_in,
                     station_units_switch_in, station_tens_switch_in};
      sw_sync_ff <= sw_meta_ff;
    end
  end

  assign sw_units = sw_sync_ff[7:4];
  assign sw_tens = sw_sync_ff[3:0];
  assign sw_rate = sw_sync_ff[19:16];

  // Wait for the synchroniser to fill before the one-time capture
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sample_cnt_ff <= '0;
    end else if (sample_cnt_ff != `FGC_SAMPLE_DELAY) begin
      sample_cnt_ff <= sample_cnt_ff + 2'h1;
    end
  end

  // Captured once; later switch moves are ignored until the next power-up
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sampled_ff <= 1'b0;
      config_valid_out <= 1'b0;
      modbus_mode_out <= 1'b0;
      unit_address_out <= '0;
      link_rate_ff <= `FGC_LINK_RATE_POS_625K;
      link_rate_error_out <= 1'b0;
      unit_count_out <= '0;
      fieldbus_10m_out <= 1'b0;
      station_number_out <= '0;
    end else if (!sampled_ff && sample_cnt_ff == `FGC_SAMPLE_DELAY) begin
      sampled_ff <= 1'b1;
      config_valid_out <= 1'b1;
      modbus_mode_out <= sw_sync_ff[25];
      unit_address_out <= {sw_sync_ff[20], sw_sync_ff[24:21]};
      link_rate_ff <= sw_rate;
      link_rate_error_out <= (sw_rate >= `FGC_LINK_RATE_POS_FIRST_BAD);
      unit_count_out <= sw_sync_ff[15:12];
      fieldbus_10m_out <= (sw_sync_ff[11:8] == `FGC_FB_RATE_POS_10M);
      station_number_out <= 7'(sw_tens) * 7'h0a + 7'(sw_units);
    end
  end

  // Only position 7 has a known bit rate; other positions give no tick
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tick_cnt_ff <= '0;
      link_bit_tick_out <= 1'b0;
    end else if (sampled_ff && link_rate_ff == `FGC_LINK_RATE_POS_625K) begin
      if (tick_cnt_ff == 6'(LINK_BIT_CYCLES - 1)) begin
        tick_cnt_ff <= '0;
        link_bit_tick_out <= 1'b1;
      end else begin
        tick_cnt_ff <= tick_cnt_ff + 6'h1;
        link_bit_tick_out <= 1'b0;
      end
    end else begin
      tick_cnt_ff <= '0;
      link_bit_tick_out <= 1'b0;
    end
  end

  // Channel scan: one command to the drivers at a time
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_ff <= fgc_scan_type_idle;
      chan_ff <= '0;
      cmd_valid_out <= 1'b0;
      cmd_chan_out <= '0;
      cmd_words_out <= '0;
    end else begin
      unique case (state_ff)
        fgc_scan_type_idle: begin
          // Direct Modbus mode leaves the gateway window unused
          if (sampled_ff && !modbus_mode_out && link.req[chan_ff] &&
              !done_ff[chan_ff]) begin
            state_ff <= fgc_scan_type_issue;
          end else begin
            chan_ff <= chan_ff + 2'h1;
          end
        end
        fgc_scan_type_issue: begin
          cmd_valid_out <= 1'b1;
          cmd_chan_out <= chan_ff;
          cmd_words_out <= link.wr_words[chan_ff*4 +: 4];
          state_ff <= fgc_scan_type_wait;
        end
        fgc_scan_type_wait: begin
          if (resp_valid_in) begin
            cmd_valid_out <= 1'b0;
            chan_ff <= chan_ff + 2'h1;
            state_ff <= fgc_scan_type_idle;
          end
        end
      endcase
    end
  end

  // Reply words land in the channel's own read window
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_words_ff <= '0;
    end else if (state_ff == fgc_scan_type_wait && resp_valid_in) begin
      rd_words_ff[chan_ff*4 +: 4] <= resp_words_in;
    end
  end

  // Done rises with the reply words, falls once the request drops
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      done_ff <= '0;
    end else begin
      for (int i = 0; i < `FGC_NUM_CHAN; i++) begin
        if (state_ff == fgc_scan_type_wait && resp_valid_in && chan_ff == 2'(i)) begin
          done_ff[i] <= 1'b1;
        end else if (!link.req[i]) begin
          done_ff[i] <= 1'b0;
        end
      end
    end
  end

  assign link.done = done_ff;
  assign link.rd_words = rd_words_ff;
endmodule // fgc_gateway

// ===== core/fgc_master.sv
`timescale 1ns/1ns
`include "fgc_params.svh"

module fgc_master (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Gateway side
  fgc_link_if.master link,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);
  import fgc_pkg::*;

  logic aw_got_ff;
  logic w_got_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  fgc_chan_mask_type req_ff;
  fgc_window_type wr_words_ff;
  logic do_write;
  logic [3:0] widx;
  logic [3:0] ridx;

  assign do_write = aw_got_ff && w_got_ff && !s_axi_bvalid_out;
  assign widx = aw_addr_ff[5:2];
  assign ridx = s_axi_araddr_in[5:2];

  // Address and data may arrive in either order
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `FGC_RESP_OKAY;
    end else begin
      s_axi_awready_out <= !aw_got_ff && !(s_axi_awvalid_in && s_axi_awready_out);
      s_axi_wready_out <= !w_got_ff && !(s_axi_wvalid_in && s_axi_wready_out);
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_got_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_got_ff <= 1'b1;
        w_data_ff <= s_axi_wdata_in;
        w_strb_ff <= s_axi_wstrb_in;
      end
      if (do_write) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= (aw_addr_ff < `FGC_REG_WIN_END && aw_addr_ff[1:0] == 2'h0 &&
                            (aw_addr_ff >= `FGC_REG_WR_BASE ||
                             aw_addr_ff == `FGC_REG_REQ_CTRL ||
                             aw_addr_ff == `FGC_REG_END_STATUS)) ?
                           `FGC_RESP_OKAY : `FGC_RESP_SLVERR;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
      end
    end
  end

  // Request flags follow software
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      req_ff <= `FGC_REQ_RESET;
    end else if (do_write && aw_addr_ff == `FGC_REG_REQ_CTRL && w_strb_ff[0]) begin
      req_ff <= w_data_ff[3:0];
    end
  end

  // Command words locked while their channel's request is up
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_words_ff <= '0;
    end else if (do_write && aw_addr_ff >= `FGC_REG_WR_BASE &&
                 aw_addr_ff < `FGC_REG_RD_BASE && !req_ff[widx[3:2]]) begin
      if (w_strb_ff[0]) begin
        wr_words_ff[widx][7:0] <= w_data_ff[7:0];
      end
      if (w_strb_ff[1]) begin
        wr_words_ff[widx][15:8] <= w_data_ff[15:8];
      end
    end
  end

  // Read path: answer one cycle after the address is taken
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= '0;
      s_axi_rresp_out <= `FGC_RESP_OKAY;
    end else begin
      s_axi_arready_out <= !s_axi_rvalid_out && !(s_axi_arvalid_in && s_axi_arready_out);
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rresp_out <= `FGC_RESP_OKAY;
        s_axi_rdata_out <= '0;
        if (s_axi_araddr_in[1:0] != 2'h0 || s_axi_araddr_in >= `FGC_REG_WIN_END) begin
          s_axi_rresp_out <= `FGC_RESP_SLVERR;
        end else if (s_axi_araddr_in == `FGC_REG_REQ_CTRL) begin
          s_axi_rdata_out <= {28'h0000000, req_ff};
        end else if (s_axi_araddr_in == `FGC_REG_END_STATUS) begin
          s_axi_rdata_out <= {28'h0000000, link.done};
        end else if (s_axi_araddr_in >= `FGC_REG_RD_BASE) begin
          s_axi_rdata_out <= {16'h0000, link.rd_words[ridx]};
        end else if (s_axi_araddr_in >= `FGC_REG_WR_BASE) begin
          s_axi_rdata_out <= {16'h0000, wr_words_ff[ridx]};
        end else begin
          s_axi_rresp_out <= `FGC_RESP_SLVERR;
        end
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end
  end

  assign link.req = req_ff;
  assign link.wr_words = wr_words_ff;
endmodule // fgc_master

// ===== bench/fgc_link_assertions.sv
`timescale 1ns/1ns
`include "fgc_params.svh"

module fgc_link_assertions (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Link
  input wire fgc_pkg::fgc_chan_mask_type req,
  input wire fgc_pkg::fgc_chan_mask_type done,
  input wire fgc_pkg::fgc_window_type wr_words,
  input wire fgc_pkg::fgc_window_type rd_words,
  // Gateway side
  input wire logic config_valid_out,
  input wire logic link_bit_tick_out,
  input wire logic cmd_valid_out,
  input wire logic [1:0] cmd_chan_out,
  input wire logic resp_valid_in
);
  import fgc_pkg::*;
  localparam int TICK = `FGC_LINK_BIT_CYCLES;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  property p_cfg_kept;
    config_valid_out |=> config_valid_out;
  endproperty
  a_cfg_kept: assert property (p_cfg_kept) else $error("config dropped");
  property p_tick;
    link_bit_tick_out |-> ##TICK link_bit_tick_out;
  endproperty
  a_tick: assert property (p_tick) else $error("bit tick period wrong");
  property p_cmd_hold;
    cmd_valid_out && !resp_valid_in |=> cmd_valid_out && $stable(cmd_chan_out);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command not held");
  property p_cmd_end;
    cmd_valid_out && resp_valid_in |=> !cmd_valid_out;
  endproperty
  a_cmd_end: assert property (p_cmd_end) else $error("command outlived reply");
  property p_cmd_req;
    cmd_valid_out |-> req[cmd_chan_out] && config_valid_out;
  endproperty
  a_cmd_req: assert property (p_cmd_req) else $error("command without request");
  property p_done_clear;
    (done & ~req) != 4'h0 |=> (done & ~$past(req)) == 4'h0;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done not cleared");
  property p_done_reply;
    (done & ~$past(done)) != 4'h0 |-> $past(resp_valid_in);
  endproperty
  a_done_reply: assert property (p_done_reply) else $error("done without reply");
  property p_rd_moves;
    !$stable(rd_words) |-> (done & ~$past(done)) != 4'h0;
  endproperty
  a_rd_moves: assert property (p_rd_moves) else $error("reply words moved alone");
  property p_words_held(int c);
    req[c] && $past(req[c]) |-> $stable(wr_words[4*c +: 4]);
  endproperty
  for (genvar c = 0; c < 4; c++) begin : g_chan
    a_words_held: assert property (p_words_held(c)) else $error("words moved");
  end

  c_done: cover property ((done & ~$past(done)) != 4'h0);
  c_reply: cover property (cmd_valid_out && resp_valid_in);
  c_tick: cover property (link_bit_tick_out ##TICK link_bit_tick_out);
endmodule // fgc_link_assertions

// ===== bench/fieldbus_gateway_switch_config_tb.sv
`timescale 1ns/1ns
`include "fgc_params.svh"

module fieldbus_gateway_switch_config_tb;
  import fgc_pkg::*;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic proto = 1'h0;
  logic ext = 1'h0;
  logic [3:0] rot = 4'h9, rate = 4'h7, cnt = 4'h2, fbr = 4'h4, units = 4'h3, tens = 4'h2;
  logic cfg, modbus, rate_err, tick, fb10m, cmd_valid;
  logic resp_valid = 1'h0;
  logic [4:0] uaddr;
  logic [3:0] ucount;
  logic [6:0] station;
  logic [1:0] cmd_chan, bresp, rresp;
  fgc_chan_words_type cmd_words;
  fgc_chan_words_type resp_words = '0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  int err_count = 0;
  int cmp_count = 0;
  int tick_gap;

  always #20 clk = ~clk;

  fgc_link_if i_fgc_link_if ();
  fgc_gateway i_fgc_gateway (.core_clk_in(clk), .nrst_in(nrst), .link(i_fgc_link_if.gateway),
    .protocol_select_switch_in(proto), .address_rotary_switch_in(rot),
    .address_extension_switch_in(ext), .link_rate_selector_in(rate),
    .attached_unit_count_switch_in(cnt), .fieldbus_rate_switch_in(fbr),
    .station_units_switch_in(units), .station_tens_switch_in(tens),
    .config_valid_out(cfg), .modbus_mode_out(modbus), .unit_address_out(uaddr),
    .link_rate_error_out(rate_err), .link_bit_tick_out(tick), .unit_count_out(ucount),
    .fieldbus_10m_out(fb10m), .station_number_out(station), .cmd_valid_out(cmd_valid),
    .cmd_chan_out(cmd_chan), .cmd_words_out(cmd_words), .resp_valid_in(resp_valid),
    .resp_words_in(resp_words));
  fgc_master i_fgc_master (.core_clk_in(clk), .nrst_in(nrst), .link(i_fgc_link_if.master),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));
  fgc_link_assertions i_fgc_link_assertions (.core_clk_in(clk), .nrst_in(nrst),
    .req(i_fgc_link_if.req), .done(i_fgc_link_if.done), .wr_words(i_fgc_link_if.wr_words),
    .rd_words(i_fgc_link_if.rd_words), .config_valid_out(cfg), .link_bit_tick_out(tick),
    .cmd_valid_out(cmd_valid), .cmd_chan_out(cmd_chan), .resp_valid_in(resp_valid));

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic final_report();
    if (err_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Bready rides along from the start, so the answer is taken on the edge it shows
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    check("bresp", 32'(er), 32'(bresp));
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    check("rdata", e, rdata);
    check("rresp", 32'(er), 32'(rresp));
  endtask

  task automatic cfg_chk(input logic [18:0] e);
    do @(posedge clk); while (cfg !== 1'h1);
    check("config", 32'(e), 32'({modbus, rate_err, fb10m, uaddr, ucount, station}));
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    final_report();
  end

  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'h1;
    cfg_chk({3'h1, 5'h09, 4'h2, 7'h17});
    rot <= 4'h5;
    proto <= 1'h1;
    fbr <= 4'h0;
    cnt <= 4'h7;
    repeat (10) @(posedge clk);
    cfg_chk({3'h1, 5'h09, 4'h2, 7'h17});
    do @(posedge clk); while (tick !== 1'h1);
    tick_gap = 0;
    do begin
      @(posedge clk);
      tick_gap++;
    end while (tick !== 1'h1);
    check("tick_gap", 32'(`FGC_LINK_BIT_CYCLES), 32'(tick_gap));
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 4; k++) begin
        axi_wr(8'h40 + 8'(16 * c + 4 * k), 32'hc000 + 32'(16 * c + k), 2'h0);
      end
      axi_wr(8'h00, 32'(1 << c), 2'h0);
      do @(posedge clk); while (cmd_valid !== 1'h1);
      check("cmd_chan", 32'(c), 32'(cmd_chan));
      for (int k = 0; k < 4; k++) begin
        check("cmd_word", 32'hc000 + 32'(16 * c + k), 32'(cmd_words[k]));
        resp_words[k] <= 16'h5a00 + 16'(16 * c + k);
      end
      axi_wr(8'h40 + 8'(16 * c), 32'hffff, 2'h0);
      rd_chk(8'h04, 32'h0, 2'h0);
      resp_valid <= 1'h1;
      @(posedge clk);
      resp_valid <= 1'h0;
      rd_chk(8'h04, 32'(1 << c), 2'h0);
      for (int k = 0; k < 4; k++) begin
        rd_chk(8'h80 + 8'(16 * c + 4 * k), 32'h5a00 + 32'(16 * c + k), 2'h0);
      end
      rd_chk(8'h80 + 8'(16 * ((c + 1) % 4)), (c == 3) ? 32'h5a00 : 32'h0, 2'h0);
      rd_chk(8'h40 + 8'(16 * c), 32'hc000 + 32'(16 * c), 2'h0);
      axi_wr(8'h00, 32'h0, 2'h0);
      rd_chk(8'h04, 32'h0, 2'h0);
    end
    rd_chk(8'h08, 32'h0, 2'h2);
    axi_wr(8'hc0, 32'h1, 2'h2);
    // Second power-up picks up every switch moved above
    rate <= 4'h8;
    ext <= 1'h1;
    nrst <= 1'h0;
    repeat (3) @(posedge clk);
    nrst <= 1'h1;
    cfg_chk({3'h6, 5'h15, 4'h7, 7'h17});
    axi_wr(8'h00, 32'h1, 2'h0);
    // Position 8 has no bit rate, so no tick for a full period
    repeat (45) begin
      @(posedge clk);
      check("tick_off", 32'h0, 32'(tick));
    end
    check("cmd_valid", 32'h0, 32'(cmd_valid));
    final_report();
  end
endmodule // fieldbus_gateway_switch_config_tb
